//--- hw/qdr_defines.svh
`ifndef QDR_DEFINES_SVH
`define QDR_DEFINES_SVH
// Register byte offsets
`define QDR_OFS_CONFIG   8'h00
`define QDR_OFS_STATUS   8'h04
`define QDR_OFS_ADDR     8'h08
// Data window: 16 words at 8'h40..8'h7C
`define QDR_MEM_SEL      2'h1
`define QDR_MEM_BYTES    64
// Reset value of the config word: pattern 34h, latency 8, rest zero
`define QDR_CONFIG_RST   32'h0034_8000
// Read opcodes
`define QDR_CMD_SDR      8'hEB
`define QDR_CMD_SDR_WIDE 8'hEC
`define QDR_CMD_DDR      8'hED
`define QDR_CMD_DDR_WIDE 8'hEE
// Last bit or nibble index of opcode, address and mode phases; preamble cycles
`define QDR_ADDR3_LAST   4'h5
`define QDR_ADDR4_LAST   4'h7
`define QDR_MODE_LAST    4'h1
`define QDR_CMD1_LAST    4'h7
`define QDR_CMD4_LAST    4'h1
`define QDR_DLP_CYCLES   4'h4
// AXI responses
`define QDR_RESP_OKAY    2'h0
`define QDR_RESP_SLVERR  2'h2
`endif

//--- hw/qdr_pkg.sv
package qdr_pkg;
	typedef enum logic [2:0] {
		QDR_IDLE   = 3'h0,
		QDR_CMD    = 3'h1,
		QDR_ADDR   = 3'h2,
		QDR_MODE   = 3'h3,
		QDR_DUMMY  = 3'h4,
		QDR_DATA   = 3'h5,
		QDR_IGNORE = 3'h6
	} qdr_state_e;

	// Config word layout
	typedef struct packed {
		logic [7:0] rsvd3;
		logic [7:0] dlp_pattern;
		logic [3:0] latency_code_field;
		logic [2:0] rsvd2;
		logic       dlp_enable;
		logic       address_length_select;
		logic       all_four_lane_command_mode;
		logic [3:0] rsvd1;
		logic       four_lane_enable_bit;
		logic       rsvd0;
	} qdr_cfg_s;

	// Link pins after synchronisation
	typedef struct packed {
		logic       cs_n;
		logic       sck;
		logic [3:0] io;
	} qdr_link_s;
endpackage : qdr_pkg

//--- hw/qdr_read_top.sv
// Operation
// - EBh address length by bit; ECh four bytes
// - Single rate address four bits per clock
// - Four-lane reads only when lane enable set
// - Single rate dummies by latency, lanes ignored
// - Data nibble per clock on falling edge
// - Address increments per byte, wraps to zero
// - Single rate mode byte takes two cycles
// - Lane command mode: opcode nibble per rise
// - EDh address length by bit; EEh four bytes
// - Double rate: nibble on every clock edge
// - Double rate dummies by latency, lanes ignored
// - Preamble in four cycles before data
// - Programmable 8-bit preamble, bit per edge
// - Lane command mode applies to double rate
// - Dummies falling to falling; zero starts immediately
`timescale 1ns/1ps
`include "qdr_defines.svh"
module qdr_read_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        cs_n,
	input  wire logic        sck,
	input  wire logic [3:0]  io_in,
	output logic      [3:0]  io_out,
	output logic      [3:0]  io_oe,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	////////////////////////////////////////////////////////////////////
	// Link synchroniser: stage one is read only by stage two
	qdr_pkg::qdr_link_s link_m;
	qdr_pkg::qdr_link_s link_s;
	logic               sck_d;
	logic               rise;
	logic               fall;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Idle levels: deselected, clock low, so no false edge follows reset
			link_m <= 6'h20;
			link_s <= 6'h20;
			sck_d  <= 1'b0;
		end else begin
			link_m <= '{cs_n: cs_n, sck: sck, io: io_in};
			link_s <= link_m;
			sck_d  <= link_s.sck;
		end
	end

	// Edges seen only while selected
	assign rise = !link_s.cs_n && link_s.sck && !sck_d;
	assign fall = !link_s.cs_n && !link_s.sck && sck_d;

	////////////////////////////////////////////////////////////////////
	// Configuration and backing store
	qdr_pkg::qdr_cfg_s cfg;
	qdr_pkg::qdr_cfg_s next_cfg;
	logic [7:0]        mem [0:`QDR_MEM_BYTES-1];

	////////////////////////////////////////////////////////////////////
	// Read sequencer state
	qdr_pkg::qdr_state_e state;
	qdr_pkg::qdr_state_e next_state;
	logic [3:0]  cnt;
	logic [3:0]  next_cnt;
	logic [7:0]  cmd;
	logic [7:0]  next_cmd;
	logic [31:0] addr;
	logic [31:0] next_addr;
	logic        wide;
	logic        next_wide;
	logic        ddr;
	logic        next_ddr;
	logic        half;
	logic        next_half;
	logic [3:0]  next_io_out;
	logic [3:0]  next_io_oe;
	logic [7:0]  cmd_v;
	logic        cmd_last;
	logic        in_edge;
	logic        out_edge;
	logic [3:0]  remain;
	logic [7:0]  cur_byte;
	logic [31:0] addr_inc;

	// Address step: 3-byte reads wrap at the top of the 24-bit space
	always_comb begin
		cur_byte = mem[addr[5:0]];
		remain   = cfg.latency_code_field - cnt;
		in_edge  = rise || (ddr && fall);
		out_edge = fall || (ddr && rise);
		if (wide) begin
			addr_inc = addr + 32'h0000_0001;
		end else begin
			addr_inc = {8'h00, addr[23:0] + 24'h00_0001};
		end
		if (cfg.all_four_lane_command_mode) begin
			cmd_v    = {cmd[3:0], link_s.io};
			cmd_last = cnt == `QDR_CMD4_LAST;
		end else begin
			cmd_v    = {cmd[6:0], link_s.io[0]};
			cmd_last = cnt == `QDR_CMD1_LAST;
		end
	end

	// Sequencer next state; select high always ends the read
	always_comb begin
		next_state  = state;
		next_cnt    = cnt;
		next_cmd    = cmd;
		next_addr   = addr;
		next_wide   = wide;
		next_ddr    = ddr;
		next_half   = half;
		next_io_out = io_out;
		next_io_oe  = io_oe;
		if (link_s.cs_n) begin
			next_state = qdr_pkg::QDR_IDLE;
			next_io_oe = 4'h0;
			next_cnt   = 4'h0;
		end else begin
			unique case (state)
				qdr_pkg::QDR_IDLE: begin
					next_state = qdr_pkg::QDR_CMD;
					next_cnt   = 4'h0;
					next_cmd   = 8'h00;
				end
				qdr_pkg::QDR_CMD: begin
					if (rise) begin
						next_cmd = cmd_v;
						next_cnt = cnt + 4'h1;
						if (cmd_last) begin
							next_cnt   = 4'h0;
							next_addr  = 32'h0000_0000;
							next_state = qdr_pkg::QDR_IGNORE;
							// Other opcodes, or lanes disabled: stay off the bus
							if (cfg.four_lane_enable_bit) begin
								if (cmd_v == `QDR_CMD_SDR || cmd_v == `QDR_CMD_DDR) begin
									next_state = qdr_pkg::QDR_ADDR;
									next_wide  = cfg.address_length_select;
									next_ddr   = cmd_v == `QDR_CMD_DDR;
								end else if (cmd_v == `QDR_CMD_SDR_WIDE
										|| cmd_v == `QDR_CMD_DDR_WIDE) begin
									next_state = qdr_pkg::QDR_ADDR;
									next_wide  = 1'b1;
									next_ddr   = cmd_v == `QDR_CMD_DDR_WIDE;
								end
							end
						end
					end
				end
				qdr_pkg::QDR_ADDR: begin
					// First nibble on a rise: the opcode's last fall holds none
					if (rise || (in_edge && cnt != 4'h0)) begin
						next_addr = {addr[27:0], link_s.io};
						next_cnt  = cnt + 4'h1;
						if (cnt == (wide ? `QDR_ADDR4_LAST : `QDR_ADDR3_LAST)) begin
							next_cnt   = 4'h0;
							next_state = qdr_pkg::QDR_MODE;
						end
					end
				end
				qdr_pkg::QDR_MODE: begin
					// Mode nibbles taken and dropped: no continuous read
					if (in_edge) begin
						next_cnt = cnt + 4'h1;
						if (cnt == `QDR_MODE_LAST) begin
							next_state = qdr_pkg::QDR_DUMMY;
							next_cnt   = 4'h0;
							if (ddr) begin
								// Mode ended on a falling edge: it counts as one
								next_cnt = 4'h1;
								if (cfg.latency_code_field == 4'h0) begin
									next_state  = qdr_pkg::QDR_DATA;
									next_io_out = cur_byte[7:4];
									next_io_oe  = 4'hF;
									next_half   = 1'b1;
								end
							end
						end
					end
				end
				qdr_pkg::QDR_DUMMY: begin
					// Lanes ignored; dummies counted on falling edges
					if (fall) begin
						if (cnt == cfg.latency_code_field) begin
							next_state  = qdr_pkg::QDR_DATA;
							next_io_out = cur_byte[7:4];
							next_io_oe  = 4'hF;
							next_half   = 1'b1;
						end else begin
							next_cnt = cnt + 4'h1;
							if (ddr && cfg.dlp_enable && remain <= `QDR_DLP_CYCLES) begin
								next_io_out = {4{cfg.dlp_pattern[3'({remain[2:0], 1'b0} - 3'h1)]}};
								next_io_oe  = 4'hF;
							end
						end
					end else if (rise && ddr && cfg.dlp_enable
							&& remain < `QDR_DLP_CYCLES) begin
						next_io_out = {4{cfg.dlp_pattern[{remain[1:0], 1'b0}]}};
						next_io_oe  = 4'hF;
					end
				end
				qdr_pkg::QDR_DATA: begin
					if (out_edge) begin
						if (half) begin
							next_io_out = cur_byte[3:0];
							next_half   = 1'b0;
							next_addr   = addr_inc;
						end else begin
							next_io_out = cur_byte[7:4];
							next_half   = 1'b1;
						end
					end
				end
				qdr_pkg::QDR_IGNORE: begin
					next_io_oe = 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state  <= qdr_pkg::QDR_IDLE;
			cnt    <= 4'h0;
			cmd    <= 8'h00;
			addr   <= 32'h0000_0000;
			wide   <= 1'b0;
			ddr    <= 1'b0;
			half   <= 1'b0;
			io_out <= 4'h0;
			io_oe  <= 4'h0;
		end else begin
			state  <= next_state;
			cnt    <= next_cnt;
			cmd    <= next_cmd;
			addr   <= next_addr;
			wide   <= next_wide;
			ddr    <= next_ddr;
			half   <= next_half;
			io_out <= next_io_out;
			io_oe  <= next_io_oe;
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: address and data may arrive in either order
	logic        aw_full;
	logic        next_aw_full;
	logic        w_full;
	logic        next_w_full;
	logic [7:0]  aw_addr;
	logic [7:0]  next_aw_addr;
	logic [31:0] w_data;
	logic [31:0] next_w_data;
	logic [3:0]  w_strb;
	logic [3:0]  next_w_strb;
	logic        do_wr;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_arready;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic [3:0]  ridx;

	always_comb begin
		next_aw_full = aw_full;
		next_w_full  = w_full;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_cfg     = cfg;
		next_arready = s_axi_arready;
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		ridx         = s_axi_araddr[5:2];
		do_wr        = aw_full && w_full && !s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_full = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_full = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		// Commit once both halves are held; status and address are read-only
		if (do_wr) begin
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = `QDR_RESP_OKAY;
			if (aw_addr == `QDR_OFS_CONFIG) begin
				for (int b = 0; b < 4; b++) begin
					if (w_strb[b]) begin
						next_cfg[8*b +: 8] = w_data[8*b +: 8];
					end
				end
			end else if (aw_addr[7:6] != `QDR_MEM_SEL && aw_addr != `QDR_OFS_STATUS
					&& aw_addr != `QDR_OFS_ADDR) begin
				next_bresp = `QDR_RESP_SLVERR;
			end
		end
		// Reserved config bits always read back as zero
		next_cfg.rsvd0 = 1'b0;
		next_cfg.rsvd1 = 4'h0;
		next_cfg.rsvd2 = 3'h0;
		next_cfg.rsvd3 = 8'h00;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rresp   = `QDR_RESP_OKAY;
			next_rdata   = 32'h0000_0000;
			if (s_axi_araddr == `QDR_OFS_CONFIG) begin
				next_rdata = cfg;
			end else if (s_axi_araddr == `QDR_OFS_STATUS) begin
				next_rdata = {24'h00_0000, ddr, wide, half, 2'h0, state};
			end else if (s_axi_araddr == `QDR_OFS_ADDR) begin
				next_rdata = addr;
			end else if (s_axi_araddr[7:6] == `QDR_MEM_SEL) begin
				next_rdata = {mem[{ridx, 2'h3}], mem[{ridx, 2'h2}],
						mem[{ridx, 2'h1}], mem[{ridx, 2'h0}]};
			end else begin
				next_rresp = `QDR_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			cfg           <= `QDR_CONFIG_RST;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `QDR_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `QDR_RESP_OKAY;
		end else begin
			aw_full       <= next_aw_full;
			w_full        <= next_w_full;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			cfg           <= next_cfg;
			// Each ready only while its own half is not held and no response waits
			s_axi_awready <= !next_aw_full && !next_bvalid;
			s_axi_wready  <= !next_w_full && !next_bvalid;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready || !s_axi_rvalid && !s_axi_arready
					&& !next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// Data window writes, byte lanes by strobe; contents have no reset
	always_ff @(posedge aclk) begin
		for (int b = 0; b < 4; b++) begin
			if (do_wr && aw_addr[7:6] == `QDR_MEM_SEL && w_strb[b]) begin
				mem[{aw_addr[5:2], 2'(b)}] <= w_data[8*b +: 8];
			end
		end
	end
endmodule : qdr_read_top

//--- test/qdr_read_properties.sv
`timescale 1ns/1ps
// Port checks of the four-lane read path and its register answers
module qdr_read_properties (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       cs_n,
	input wire logic       sck,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid
);
	logic       sck_q;
	logic [7:0] rises;

	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////
	// Link clock rises within a frame; saturates so it never wraps
	always_ff @(posedge aclk) begin
		sck_q <= sck;
		if (!aresetn || cs_n)
			rises <= 8'h00;
		else if (sck && !sck_q && rises != 8'hFF)
			rises <= rises + 8'h01;
	end

	////////////////////////////////////////////////////////////
	// Link side
	a_oe_lanes_equal: assert property (io_oe == 4'h0 || io_oe == 4'hF)
		else $error("lane enables differ");
	a_idle_quiet: assert property (cs_n [*6] |-> io_oe == 4'h0)
		else $error("lanes driven while deselected");
	a_oe_start_fall: assert property ($rose(io_oe[0]) |->
		!sck && $past(sck, 8))
		else $error("drive did not start on a falling edge");
	a_out_after_edge: assert property ($changed(io_out) && io_oe[0]
		&& $past(io_oe[0]) |-> $past(sck, 2) != $past(sck, 8))
		else $error("output changed without a clock edge");
	a_oe_after_rises: assert property ($rose(io_oe[0]) |->
		rises >= 8'h06)
		else $error("drive began before header complete");

	////////////////////////////////////////////////////////////
	// Register bus answers
	a_r_after_take: assert property ($rose(s_axi_rvalid) |->
		$past(s_axi_arvalid) && $past(s_axi_arready))
		else $error("read answer without request");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while answer pending");
	a_b_after_take: assert property ($rose(s_axi_bvalid) |->
		$past(s_axi_awready) == 1'b0 && $past(s_axi_wready) == 1'b0)
		else $error("write answer too early");
	a_b_clears: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid)
		else $error("write answer not retired");
endmodule : qdr_read_properties

bind qdr_read_top qdr_read_properties u_qdr_read_properties (
	.aclk, .aresetn, .cs_n, .sck, .io_out, .io_oe, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid
);

//--- test/qdr_host_model.sv
`timescale 1ns/1ps
// Host controller on the link: select, clock and the four lanes
module qdr_host_model (
	input  wire logic       aclk,
	output logic            cs_n,
	output logic            sck,
	output logic      [3:0] io_in,
	input  wire logic [3:0] io_out,
	input  wire logic [3:0] io_oe
);
	logic [3:0] io_h;
	logic [7:0] rx [16];
	logic [3:0] dl [8];
	logic       oe_seen;

	// Released lanes toggle so a stale value never passes for data
	assign io_in = io_oe[0] ? io_out : io_h;

	// Idle: deselected, clock parked low
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		io_h = 4'h0;
		oe_seen = 1'b0;
	end

	// Half period of 80 ns: sample, set lanes, then the clock edge
	task automatic half(input logic v, input logic [3:0] d, input logic oe,
		output logic [3:0] s);
		repeat (12) @(posedge aclk);
		s = io_in;
		if (io_oe[0]) oe_seen = 1'b1;
		io_h <= oe ? d : ~io_h;
		repeat (4) @(posedge aclk);
		sck <= v;
	endtask : half

	// One read frame; bytes land in rx, preamble edges in dl
	task automatic frame(input logic [7:0] op, input logic all_four_lane_protocol,
		input logic ddr, input int nib, input logic [31:0] a,
		input int lc, input int nb);
		logic [3:0] s;
		logic [3:0] d;
		int         n;
		oe_seen = 1'b0;
		@(posedge aclk);
		cs_n <= 1'b0;
		for (int i = 0; i < (all_four_lane_protocol ? 2 : 8); i++) begin
			d = all_four_lane_protocol ? op[7 - 4*i -: 4] : {3'h0, op[7 - i]};
			half(1'b1, d, 1'b1, s);
			half(1'b0, d, 1'b1, s);
		end
		// Address MSB first, then two mode nibbles of zero
		for (int i = 0; i < nib + 2; i++) begin
			d = (i < nib) ? a[4*(nib - 1 - i) +: 4] : 4'h0;
			if (ddr) half(~i[0], d, 1'b1, s);
			else begin
				half(1'b1, d, 1'b1, s);
				if (i < nib + 1) half(1'b0, d, 1'b1, s);
			end
		end
		// Select held low, lanes released through dummies and data
		for (int e = 1; e <= 2*lc + (ddr ? 2 : 4)*nb; e++) begin
			half(ddr ? e[0] : ~e[0], 4'h0, 1'b0, s);
			n = ddr ? e - 1 - 2*lc : e/2 - 1 - lc;
			if (ddr && n < 0 && n >= -8) dl[n + 8] = s;
			if (n >= 0 && (ddr || !e[0])) rx[n/2][(n[0] ? 3 : 7) -: 4] = s;
		end
		half(1'b0, 4'h0, 1'b0, s);
		repeat (16) @(posedge aclk);
		cs_n <= 1'b1;
		repeat (16) @(posedge aclk);
	endtask : frame
endmodule : qdr_host_model

//--- test/tb.sv
`timescale 1ns/1ps
`include "qdr_defines.svh"
module tb;
	logic        aclk = 1'b0;
	logic        aresetn;
	logic        cs_n;
	logic        sck;
	logic [3:0]  io_in;
	logic [3:0]  io_out;
	logic [3:0]  io_oe;
	logic [7:0]  s_axi_awaddr;
	logic [7:0]  s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_bresp;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic [7:0]  mem [64];
	int          n_errors = 0;
	int          num_checks = 0;

	////////////////////////////////////////////////////////////
	// Device and its host
	qdr_read_top u_qdr_read_top (
		.aclk, .aresetn, .cs_n, .sck, .io_in, .io_out, .io_oe,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready
	);
	qdr_host_model u_qdr_host_model (
		.aclk, .cs_n, .sck, .io_in, .io_out, .io_oe
	);

	// 200 MHz clock
	always #2.5 aclk = ~aclk;

	////////////////////////////////////////////////////////////
	// Compare, count and report
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error t=%0t mismatch %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	// Bus master: both halves offered together, each dropped when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	////////////////////////////////////////////////////////////
	// Configure, run one frame, judge bytes, preamble and drive
	task automatic rd_link(input logic en, input logic all_four_lane_protocol, input logic al,
		input logic data_learning_preamble, input int lc, input logic [7:0] op,
		input logic [31:0] a, input int nb, input logic [7:0] pat);
		qdr_pkg::qdr_cfg_s c;
		logic [1:0]        r;
		logic              ok;
		c = '0;
		c.four_lane_enable_bit = en;
		c.all_four_lane_command_mode = all_four_lane_protocol;
		c.address_length_select = al;
		c.dlp_enable = data_learning_preamble;
		c.latency_code_field = 4'(lc);
		c.dlp_pattern = pat;
		axi_wr(`QDR_OFS_CONFIG, c, r);
		ok = en && (op inside {`QDR_CMD_SDR, `QDR_CMD_SDR_WIDE,
			`QDR_CMD_DDR, `QDR_CMD_DDR_WIDE});
		u_qdr_host_model.frame(op, all_four_lane_protocol,
			op inside {`QDR_CMD_DDR, `QDR_CMD_DDR_WIDE},
			(al || op inside {`QDR_CMD_SDR_WIDE, `QDR_CMD_DDR_WIDE})
			? 8 : 6, a, lc, nb);
		chk(u_qdr_host_model.oe_seen, ok);
		for (int k = 0; k < nb && ok; k++)
			chk(u_qdr_host_model.rx[k], mem[6'(a + k)]);
		for (int k = 0; k < 8 && data_learning_preamble; k++)
			chk(u_qdr_host_model.dl[k], {4{pat[7 - k]}});
	endtask : rd_link

	// Reset value, unmapped access, then fill the memory window
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(`QDR_OFS_CONFIG, d, r);
		chk(d, `QDR_CONFIG_RST);
		axi_rd(8'h10, d, r);
		chk(r, `QDR_RESP_SLVERR);
		axi_wr(8'h10, 32'h0000_0001, r);
		chk(r, `QDR_RESP_SLVERR);
		for (int i = 0; i < 64; i++)
			mem[i] = 8'(i * 37 + 91);
		for (int w = 0; w < 16; w++)
			axi_wr(8'(8'h40 + 4*w), {mem[4*w+3], mem[4*w+2],
				mem[4*w+1], mem[4*w]}, r);
		axi_rd(8'h44, d, r);
		chk(d, {mem[7], mem[6], mem[5], mem[4]});
	endtask : t_regs

	task automatic t_sdr_plain;
		rd_link(1'b1, 1'b0, 1'b0, 1'b0, 1, 8'hEB, 32'h3D, 4, 8'h00);
	endtask : t_sdr_plain

	task automatic t_sdr_cmd4;
		rd_link(1'b1, 1'b1, 1'b1, 1'b0, 0, 8'hEB, 32'h1234567C, 3, 8'h00);
	endtask : t_sdr_cmd4

	task automatic t_sdr_wide;
		rd_link(1'b1, 1'b0, 1'b0, 1'b0, 3, 8'hEC, 32'hFF07, 2, 8'h00);
	endtask : t_sdr_wide

	task automatic t_ddr_plain;
		rd_link(1'b1, 1'b0, 1'b0, 1'b0, 2, 8'hED, 32'hA5A5, 5, 8'h00);
		rd_link(1'b1, 1'b0, 1'b1, 1'b0, 0, 8'hED, 32'h0123, 2, 8'h00);
	endtask : t_ddr_plain

	task automatic t_ddr_dlp;
		rd_link(1'b1, 1'b1, 1'b0, 1'b1, 6, 8'hEE, 32'h80000010, 3, 8'hA6);
	endtask : t_ddr_dlp

	task automatic t_refused;
		rd_link(1'b0, 1'b0, 1'b0, 1'b0, 1, 8'hEB, 32'h10, 2, 8'h00);
		rd_link(1'b1, 1'b0, 1'b0, 1'b0, 1, 8'h0B, 32'h10, 2, 8'h00);
	endtask : t_refused

	task automatic t_wrap;
		logic [31:0] d;
		logic [1:0]  r;
		rd_link(1'b1, 1'b0, 1'b0, 1'b0, 1, 8'hEB, 32'hFFFFFE, 4, 8'h00);
		axi_rd(`QDR_OFS_ADDR, d, r);
		chk(d, 32'h0000_0002);
	endtask : t_wrap

	////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid,
			s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		t_regs;
		t_sdr_plain;
		t_sdr_cmd4;
		t_sdr_wide;
		t_ddr_plain;
		t_ddr_dlp;
		t_refused;
		t_wrap;
		complete_run;
	end

	// Watchdog: far beyond the expected run length
	initial begin
		repeat (60000) @(posedge aclk);
		n_errors++;
		$display("Error t=%0t watchdog expired", $time);
		complete_run;
	end
endmodule : tb
